// >>> sgdc_regs.vh
// Purpose: Register offsets, field positions and reset values of the
//          scatter-gather DMA channel control block.
// Assumes: Included by the channel design file of the block by its bare name.
// Notes:   Offsets are register indices; byte address is index times four.
`ifndef SGDC_REGS_VH
`define SGDC_REGS_VH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define SGDC_IDX_START_QUEUE 4'h0
`define SGDC_IDX_DONE_QUEUE 4'h1
`define SGDC_IDX_PTR_HI 4'h2
`define SGDC_IDX_PTR_LO 4'h3
`define SGDC_IDX_LEN_HI 4'h4
`define SGDC_IDX_LEN_LO 4'h5
`define SGDC_IDX_TOTAL_PKTS 4'h6
`define SGDC_IDX_DONE_PKTS 4'h7
`define SGDC_IDX_STATUS 4'h8
`define SGDC_IDX_COMMAND 4'h9
`define SGDC_IDX_PAIR_CTRL 4'hA

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define SGDC_STS_BUSY 7
`define SGDC_STS_BUS_DONE 6
`define SGDC_STS_DONE_FULL 3
`define SGDC_STS_DONE_EMPTY 2
`define SGDC_STS_START_FULL 1
`define SGDC_STS_START_EMPTY 0

// ----------------------------------------------------------------------
// Command fields
// ----------------------------------------------------------------------
`define SGDC_CMD_HEADER 2
`define SGDC_CMD_BUFFER 1
`define SGDC_CMD_ENABLE 0
`define SGDC_CMD_RESET 3'h0

// ----------------------------------------------------------------------
// Header and packet constants
// ----------------------------------------------------------------------
`define SGDC_HDR_ADDR_LO 8'h08
`define SGDC_PLAIN_ADDR_LO 8'h00
`define SGDC_HDR_SIZE_OFS 8'h06
`define SGDC_HDR_BYTES 16'h0008
`define SGDC_HDR_RD_ADJ 16'h0009
`define SGDC_ONE 16'h0001

`endif

// >>> sgdc_queue.v
// Purpose: Small synchronous queue of packet numbers with fill count.
// Assumes: Pushes into a full queue and pops from an empty one are dropped.
// Notes:   Head word is shown combinationally from the array.
`timescale 1ns/100ps
`default_nettype none

module sgdc_queue #(
    parameter WIDTH = 5,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk, // System clock
    input wire srst, // Synchronous reset, active high
    input wire push, // Write one entry
    input wire [WIDTH-1:0] push_data, // Entry to write
    input wire pop, // Remove oldest entry
    output wire [WIDTH-1:0] head, // Oldest entry
    output wire full, // No room left
    output wire empty, // Nothing stored
    output wire [AW:0] count // Entries stored
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire do_push;
    wire do_pop;

    // Guard against overflow and underflow
    assign do_push = push & (count_reg != DEPTH[AW:0]);
    assign do_pop = pop & (count_reg != {(AW+1){1'b0}});
    assign head = mem[rd_ptr_reg];
    assign full = (count_reg == DEPTH[AW:0]);
    assign empty = (count_reg == {(AW+1){1'b0}});
    assign count = count_reg;

    // Storage array
    always @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= push_data;
        end
    end

    // Pointers and fill count
    always @(posedge clk) begin
        if (srst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (do_push) begin
                wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (do_pop) begin
                rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (do_push & ~do_pop) begin
                count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
            end else if (do_pop & ~do_push) begin
                count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // sgdc_queue

`default_nettype wire

// >>> sgdc_channel.v
// Purpose: Command and queue-status logic of one scatter-gather DMA channel.
// Assumes: Avalon-MM slave with waitrequest, 32-bit data, byte addresses.
// Notes:   The legacy DMA core and packet memory sit outside this module.
//
// Functional notes
// - Status bit 1 reads 1 while the start queue is full.
// - Status bit 0 reads 1 while the start queue is empty.
// - Command bits 7 to 3 always read back as zero.
// - Command bit 2 marks a packet header; only with buffer operation.
// - Command bit 1 selects buffer operation (1) or bus memory (0).
// - Bus memory: count is length minus one, address from pointer registers.
// - Buffer without header: count length minus one, address packet high, low 0.
// - Buffer with header: address high from packet, low byte 8.
// - Buffer read with header: count is header size minus 9.
// - Header size 8: no transfer, packet still pushed to done queue.
// - Buffer write with header: count length minus one, length plus 8 at offset 6.
// - Command bit 0 enables the channel when 1, disables when 0.
// - Disable mid-cycle, buffer operation: push packet, return to idle.
// - Disable mid-cycle, bus memory operation: simply return to idle.
// - Paired transfer disabled: push buffer packet, skip updates, go idle.
// - Paired transfers only between packet buffer and bus memory.
// - Status bit 7 is set while a transfer is in progress.
// - Reading the done queue returns oldest packet and pops it.
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "sgdc_regs.vh"

module sgdc_channel #(
    parameter QUEUE_DEPTH = 16,
    parameter QUEUE_AW = 4
) (
    input wire clk, // System clock, 25 MHz
    input wire srst, // Synchronous reset, active high
    input wire [5:0] avs_address, // Byte address
    input wire avs_read, // Read request
    input wire avs_write, // Write request
    input wire [31:0] avs_writedata, // Write data, low byte used
    input wire [3:0] avs_byteenable, // Byte lanes
    output wire avs_waitrequest, // Stall until answer
    output reg [31:0] avs_readdata, // Read data
    input wire partner_enable, // Enable bit of the paired channel
    input wire partner_buffer_select, // Operation select of the paired channel
    output wire channel_enable, // This channel's enable bit
    output wire buffer_select, // This channel's operation select
    input wire buffer_read, // Core moves data out of packet buffer
    output reg core_load, // Load pulse for the legacy DMA core
    output reg [15:0] core_count, // Count for the core
    output reg [15:0] core_addr, // Start address for the core
    input wire terminal_count, // Core reached terminal count
    output reg hdr_req, // Header access request
    output reg hdr_we, // Header access is a write
    output reg [15:0] hdr_addr, // Header byte address
    output reg [15:0] hdr_wdata, // Header size to store
    input wire hdr_ack, // Header access done
    input wire [15:0] hdr_rdata // Header size read back
);
    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    localparam ST_IDLE = 6'b000001;
    localparam ST_FETCH = 6'b000010;
    localparam ST_HDR_RD = 6'b000100;
    localparam ST_HDR_WR = 6'b001000;
    localparam ST_LOAD = 6'b010000;
    localparam ST_RUN = 6'b100000;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    reg [2:0] cmd_reg;
    reg pair_reg;
    reg [15:0] pointer_reg;
    reg [15:0] length_reg;
    reg [4:0] total_reg;
    reg bus_done_reg;
    reg [5:0] state_reg;
    reg [4:0] pkt_reg;
    reg ack_reg;
    reg [7:0] rd_byte;
    wire [3:0] reg_idx;
    wire req;
    wire wr_take;
    wire rd_take;
    wire start_push;
    wire done_pop;
    reg done_push;
    wire [4:0] start_head;
    wire [4:0] done_head;
    wire start_full;
    wire start_empty;
    wire done_full;
    wire done_empty;
    wire [QUEUE_AW:0] done_count;
    wire header_present;
    wire pair_active;
    wire abort;
    wire busy;
    wire [15:0] pkt_base;
    wire [7:0] status_byte;

    // High address byte formed from the packet number
    function [7:0] pkt_page;
        input [4:0] pkt;
        begin
            pkt_page = {3'h0, pkt};
        end
    endfunction

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    // One wait cycle, then the request completes
    assign reg_idx = avs_address[5:2];
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_reg;
    assign wr_take = avs_write & ack_reg & avs_byteenable[0];
    assign rd_take = avs_read & ack_reg;

    // Acknowledge toggle
    always @(posedge clk) begin
        if (srst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end

    // Read data captured one edge before the completing edge
    always @(posedge clk) begin
        if (srst) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read & ~ack_reg) begin
            avs_readdata <= {24'h000000, rd_byte};
        end
    end

    // ------------------------------------------------------------------
    // Queues
    // ------------------------------------------------------------------
    // Writing the start index pushes a packet number
    assign start_push = wr_take & (reg_idx == `SGDC_IDX_START_QUEUE);
    assign done_pop = rd_take & (reg_idx == `SGDC_IDX_DONE_QUEUE);

    sgdc_queue #(
        .WIDTH(5),
        .DEPTH(QUEUE_DEPTH),
        .AW(QUEUE_AW)
    ) u_start_queue (
        .clk(clk),
        .srst(srst),
        .push(start_push),
        .push_data(avs_writedata[4:0]),
        .pop(state_reg == ST_FETCH),
        .head(start_head),
        .full(start_full),
        .empty(start_empty),
        .count()
    );

    sgdc_queue #(
        .WIDTH(5),
        .DEPTH(QUEUE_DEPTH),
        .AW(QUEUE_AW)
    ) u_done_queue (
        .clk(clk),
        .srst(srst),
        .push(done_push),
        .push_data(pkt_reg),
        .pop(done_pop),
        .head(done_head),
        .full(done_full),
        .empty(done_empty),
        .count(done_count)
    );

    // ------------------------------------------------------------------
    // Decoded control
    // ------------------------------------------------------------------
    // Header bit counts only for buffer operation
    assign header_present = cmd_reg[`SGDC_CMD_HEADER] & cmd_reg[`SGDC_CMD_BUFFER];
    assign channel_enable = cmd_reg[`SGDC_CMD_ENABLE];
    assign buffer_select = cmd_reg[`SGDC_CMD_BUFFER];
    // Pairing only buffer with bus memory
    assign pair_active = pair_reg & (buffer_select != partner_buffer_select);
    assign abort = ~channel_enable | (pair_active & ~partner_enable);
    assign busy = (state_reg != ST_IDLE);
    assign pkt_base = {pkt_page(pkt_reg), `SGDC_PLAIN_ADDR_LO};

    assign status_byte = {busy, bus_done_reg, 2'b00, done_full, done_empty, start_full, start_empty};

    // Register read multiplexer
    always @* begin
        case (reg_idx)
            `SGDC_IDX_DONE_QUEUE: rd_byte = {3'h0, done_head};
            `SGDC_IDX_PTR_HI: rd_byte = pointer_reg[15:8];
            `SGDC_IDX_PTR_LO: rd_byte = pointer_reg[7:0];
            `SGDC_IDX_LEN_HI: rd_byte = length_reg[15:8];
            `SGDC_IDX_LEN_LO: rd_byte = length_reg[7:0];
            `SGDC_IDX_TOTAL_PKTS: rd_byte = {3'h0, total_reg};
            `SGDC_IDX_DONE_PKTS: rd_byte = {{(7-QUEUE_AW){1'b0}}, done_count};
            `SGDC_IDX_STATUS: rd_byte = status_byte;
            `SGDC_IDX_COMMAND: rd_byte = {5'h00, cmd_reg};
            `SGDC_IDX_PAIR_CTRL: rd_byte = {7'h00, pair_reg};
            default: rd_byte = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    // Command, pairing, pointer and length registers
    always @(posedge clk) begin
        if (srst) begin
            cmd_reg <= `SGDC_CMD_RESET;
            pair_reg <= 1'b0;
            pointer_reg <= 16'h0000;
            length_reg <= 16'h0000;
        end else begin
            if (wr_take & (reg_idx == `SGDC_IDX_COMMAND)) begin
                // Select bits assumed stable while busy
                cmd_reg <= avs_writedata[2:0];
            end
            if (wr_take & (reg_idx == `SGDC_IDX_PAIR_CTRL)) begin
                pair_reg <= avs_writedata[0];
            end
            if (wr_take & (reg_idx == `SGDC_IDX_PTR_HI)) begin
                pointer_reg[15:8] <= avs_writedata[7:0];
            end else if (wr_take & (reg_idx == `SGDC_IDX_PTR_LO)) begin
                pointer_reg[7:0] <= avs_writedata[7:0];
            end else if ((state_reg == ST_RUN) & ~abort & terminal_count & ~buffer_select) begin
                // Bus pointer advances past a finished block
                pointer_reg <= pointer_reg + length_reg;
            end
            if (wr_take & (reg_idx == `SGDC_IDX_LEN_HI)) begin
                length_reg[15:8] <= avs_writedata[7:0];
            end else if (wr_take & (reg_idx == `SGDC_IDX_LEN_LO)) begin
                length_reg[7:0] <= avs_writedata[7:0];
            end
        end
    end

    // Packets held by the channel, start pushes minus done pops
    always @(posedge clk) begin
        if (srst) begin
            total_reg <= 5'h00;
        end else if (start_push & ~start_full & ~(done_pop & ~done_empty)) begin
            total_reg <= total_reg + 5'h01;
        end else if (done_pop & ~done_empty & ~(start_push & ~start_full)) begin
            total_reg <= total_reg - 5'h01;
        end
    end

    // Bus transfer done flag, set wins over the disable clear
    always @(posedge clk) begin
        if (srst) begin
            bus_done_reg <= 1'b0;
        end else if ((state_reg == ST_RUN) & ~abort & terminal_count & ~buffer_select) begin
            bus_done_reg <= 1'b1;
        end else if (~channel_enable) begin
            bus_done_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------------
    // Done queue push decision
    always @* begin
        done_push = 1'b0;
        if (busy & (state_reg != ST_FETCH) & abort) begin
            // Disabled buffer channel reports its packet
            // Bus memory channel just goes idle
            done_push = buffer_select;
        end else if ((state_reg == ST_HDR_RD) & hdr_ack & (hdr_rdata == `SGDC_HDR_BYTES)) begin
            done_push = 1'b1;
        end else if ((state_reg == ST_RUN) & terminal_count) begin
            done_push = buffer_select;
        end
    end

    // Sequencer state and outputs to the core and packet memory
    always @(posedge clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            pkt_reg <= 5'h00;
            core_load <= 1'b0;
            core_count <= 16'h0000;
            core_addr <= 16'h0000;
            hdr_req <= 1'b0;
            hdr_we <= 1'b0;
            hdr_addr <= 16'h0000;
            hdr_wdata <= 16'h0000;
        end else begin
            core_load <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    hdr_req <= 1'b0;
                    if (channel_enable & ~start_empty) begin
                        state_reg <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    pkt_reg <= start_head;
                    if (header_present) begin
                        hdr_req <= 1'b1;
                        hdr_addr <= {pkt_page(start_head), `SGDC_HDR_SIZE_OFS};
                        hdr_we <= ~buffer_read;
                        // Stored size is payload plus header
                        hdr_wdata <= length_reg + `SGDC_HDR_BYTES;
                        state_reg <= buffer_read ? ST_HDR_RD : ST_HDR_WR;
                    end else begin
                        state_reg <= ST_LOAD;
                    end
                end
                ST_HDR_RD: begin
                    if (abort) begin
                        hdr_req <= 1'b0;
                        state_reg <= ST_IDLE;
                    end else if (hdr_ack) begin
                        hdr_req <= 1'b0;
                        core_count <= hdr_rdata - `SGDC_HDR_RD_ADJ;
                        core_addr <= {pkt_page(pkt_reg), `SGDC_HDR_ADDR_LO};
                        core_load <= (hdr_rdata != `SGDC_HDR_BYTES);
                        state_reg <= (hdr_rdata == `SGDC_HDR_BYTES) ? ST_IDLE : ST_RUN;
                    end
                end
                ST_HDR_WR: begin
                    if (abort) begin
                        hdr_req <= 1'b0;
                        state_reg <= ST_IDLE;
                    end else if (hdr_ack) begin
                        hdr_req <= 1'b0;
                        hdr_we <= 1'b0;
                        core_count <= length_reg - `SGDC_ONE;
                        core_addr <= {pkt_page(pkt_reg), `SGDC_HDR_ADDR_LO};
                        core_load <= 1'b1;
                        state_reg <= ST_RUN;
                    end
                end
                ST_LOAD: begin
                    if (abort) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        core_count <= length_reg - `SGDC_ONE;
                        core_addr <= buffer_select ? pkt_base : pointer_reg;
                        core_load <= 1'b1;
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (abort | terminal_count) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // sgdc_channel

`default_nettype wire

// >>> sgdc_monitor.sv
// Purpose: Port assertions of the channel block.
// Assumes: Bound to each channel.
// Notes:   Header size latched per handshake.
`timescale 1ns/100ps
`default_nettype none
module sgdc_monitor (
    input wire clk, // Clock
    input wire srst, // Reset
    input wire [5:0] avs_address, // Address
    input wire avs_read, // Read
    input wire avs_write, // Write
    input wire avs_waitrequest, // Stall
    input wire [31:0] avs_readdata, // Read data
    input wire channel_enable, // Enable bit
    input wire partner_enable, // Paired enable
    input wire buffer_select, // Op select
    input wire core_load, // Load pulse
    input wire [15:0] core_count, // Count
    input wire [15:0] core_addr, // Address
    input wire hdr_req, // Header request
    input wire hdr_we, // Header write
    input wire hdr_ack, // Header done
    input wire [15:0] hdr_addr, // Header address
    input wire [15:0] hdr_wdata, // Header store value
    input wire [15:0] hdr_rdata // Header read value
);
    reg [15:0] size_reg;
    reg pend_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Latched header size
    always @(posedge clk) begin
        if (srst || core_load) begin
            pend_reg <= 1'b0;
        end else if (hdr_req && hdr_ack && (hdr_we || hdr_rdata != 16'h0008)) begin
            pend_reg <= 1'b1;
            size_reg <= hdr_we ? hdr_wdata : hdr_rdata;
        end
    end
    sequence s_req_start;
        $rose(avs_read || avs_write);
    endsequence
    sequence s_hdr_ok;
        hdr_req && hdr_ack && (hdr_we || hdr_rdata != 16'h0008);
    endsequence
    sequence s_hdr_empty;
        hdr_req && hdr_ack && !hdr_we && hdr_rdata == 16'h0008;
    endsequence
    a_one_wait: assert property (s_req_start |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not after one wait cycle");
    a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest without request");
    a_cmd_zero: assert property (avs_read && !avs_waitrequest && avs_address[5:2] == 4'h9
        |-> avs_readdata[31:3] == 29'h0) else $error("command reserved bits not zero");
    a_hdr_place: assert property (hdr_req |-> hdr_addr[7:0] == 8'h06)
        else $error("header size offset wrong");
    a_buf_addr: assert property (core_load && buffer_select
        |-> core_addr[7:0] == (pend_reg ? 8'h08 : 8'h00)) else $error("buffer address low byte wrong");
    a_hdr_count: assert property (core_load && pend_reg |-> core_count == size_reg - 16'h0009)
        else $error("header count wrong");
    a_load_after: assert property (s_hdr_ok |-> ##[1:2] core_load)
        else $error("no load after header");
    a_empty_skip: assert property (s_hdr_empty |=> !core_load [*3])
        else $error("load for empty payload");
    a_hdr_hold: assert property (hdr_req && !hdr_ack && channel_enable && partner_enable |=> hdr_req)
        else $error("header request dropped");
    a_stop_load: assert property (!channel_enable ##1 !channel_enable |=> !core_load)
        else $error("load while disabled");
endmodule // sgdc_monitor
bind sgdc_channel sgdc_monitor mon_u (.*);
`default_nettype wire

// >>> sgdc_core_model.sv
// Purpose: Behavioural core and packet memory beside the channel.
// Assumes: One transfer at a time.
// Notes:   Slow mode raises the wait count of every answer from one to twelve.
`timescale 1ns/100ps
`default_nettype none
module sgdc_core_model (
    input wire clk, // Clock
    input wire srst, // Reset
    input wire slow, // Long answers
    input wire [15:0] hdr_size, // Size held in header
    input wire core_load, // Core load
    input wire hdr_req, // Header request
    output logic hdr_ack, // Header done
    output wire [15:0] hdr_rdata, // Header value
    output logic terminal_count // Transfer end
);
    reg [3:0] hwait_reg;
    reg [3:0] twait_reg;
    reg run_reg;
    wire [3:0] lim = slow ? 4'hC : 4'h1;
    // Read value is only valid with the acknowledge
    assign hdr_rdata = hdr_ack ? hdr_size : ~hdr_size;
    // Answer header accesses and end each transfer after a wait
    always @(posedge clk) begin
        if (srst) begin
            hwait_reg <= 4'h0;
            twait_reg <= 4'h0;
            run_reg <= 1'b0;
            hdr_ack <= 1'b0;
            terminal_count <= 1'b0;
        end else begin
            hwait_reg <= (hdr_req && !hdr_ack) ? hwait_reg + 4'h1 : 4'h0;
            hdr_ack <= hdr_req && !hdr_ack && hwait_reg == lim;
            run_reg <= core_load || (run_reg && !terminal_count);
            twait_reg <= (run_reg && !terminal_count) ? twait_reg + 4'h1 : 4'h0;
            terminal_count <= run_reg && !terminal_count && twait_reg == lim;
        end
    end
endmodule // sgdc_core_model
`default_nettype wire

// >>> tb_top.sv
// Purpose: Self-checking bench of the channel block.
// Assumes: Queue depth four.
// Notes:   Registers reached over Avalon-MM only.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic partner_enable = 1'b1, buffer_read = 1'b1, slow = 1'b0, partner_buffer_select = 1'b0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [5:0] avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0;
    logic [15:0] hdr_size = 16'h0020;
    logic [15:0] rv, ld_cnt, ld_adr, hw;
    wire avs_waitrequest, channel_enable, buffer_select, core_load, terminal_count, hdr_req, hdr_we, hdr_ack;
    wire [31:0] avs_readdata;
    wire [15:0] core_count, core_addr, hdr_addr, hdr_wdata, hdr_rdata;
    int ld_n = 0, n_mismatch = 0, total_checks = 0;
    sgdc_channel #(.QUEUE_DEPTH(4), .QUEUE_AW(2)) dut_u (.*);
    sgdc_core_model core_u (.*);
    // Clock at 25 MHz
    initial begin
        forever #20 clk = ~clk;
    end
    // Record core loads and stored header sizes
    always @(posedge clk) begin
        if (core_load) begin
            ld_n <= ld_n + 1;
            ld_cnt <= core_count;
            ld_adr <= core_addr;
        end
        if (hdr_req && hdr_ack && hdr_we) begin
            hw <= hdr_wdata;
        end
    end
    task bus(input logic rd, input logic [3:0] idx, input logic [7:0] wd);
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h000000, wd};
        avs_read <= rd;
        avs_write <= !rd;
        do @(posedge clk);
        while (avs_waitrequest !== 1'b0);
        rv = {8'h00, avs_readdata[7:0]};
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task idle;
        for (int i = 0; i < 40; i++) begin
            bus(1'b1, 4'h8, 8'h00);
            if (rv[7] === 1'b0 && rv[0] === 1'b1) break;
        end
    endtask
    task wl;
        int n;
        n = ld_n;
        for (int i = 0; i < 60 && ld_n == n; i++) @(posedge clk);
    endtask
    task start(input logic [7:0] cmd, input logic [4:0] p);
        bus(1'b0, 4'h9, 8'h00);
        bus(1'b0, 4'h9, cmd);
        bus(1'b0, 4'h0, {3'h0, p});
    endtask
    task pop(input logic [15:0] e);
        bus(1'b1, 4'h1, 8'h00);
        chk("done head", e, rv);
    endtask
    task t_regs;
        int n;
        n = ld_n;
        bus(1'b1, 4'h8, 8'h00);
        chk("status", 16'h0005, rv);
        bus(1'b0, 4'h9, 8'hF8);
        bus(1'b1, 4'h9, 8'h00);
        chk("command", 16'h0000, rv);
        bus(1'b1, 4'hF, 8'h00);
        chk("unmapped", 16'h0000, rv);
        for (int i = 1; i < 5; i++) begin
            bus(1'b0, 4'h0, 8'(i));
            bus(1'b1, 4'h8, 8'h00);
            chk("queue flags", (i == 4) ? 16'h0002 : 16'h0000, rv & 16'h0003);
        end
        bus(1'b0, 4'h2, 8'h12);
        bus(1'b0, 4'h3, 8'h34);
        bus(1'b0, 4'h4, 8'h00);
        bus(1'b0, 4'h5, 8'h10);
        bus(1'b0, 4'h9, 8'h01);
        idle;
        chk("loads", 16'h0004, 16'(ld_n - n));
        chk("count", 16'h000F, ld_cnt);
        chk("address", 16'h1264, ld_adr);
        bus(1'b1, 4'h8, 8'h00);
        chk("status", 16'h0045, rv);
        $display("test regs done");
    endtask
    task t_buf;
        int n;
        start(8'h03, 5'h05);
        idle;
        chk("count", 16'h000F, ld_cnt);
        chk("address", 16'h0500, ld_adr);
        bus(1'b1, 4'h7, 8'h00);
        chk("done pkts", 16'h0001, rv);
        pop(16'h0005);
        start(8'h07, 5'h03);
        idle;
        chk("count", 16'h0017, ld_cnt);
        chk("address", 16'h0308, ld_adr);
        pop(16'h0003);
        hdr_size <= 16'h0008;
        n = ld_n;
        bus(1'b0, 4'h0, 8'h09);
        idle;
        chk("loads", 16'h0000, 16'(ld_n - n));
        pop(16'h0009);
        buffer_read <= 1'b0;
        start(8'h07, 5'h0A);
        idle;
        chk("stored size", 16'h0018, hw);
        chk("count", 16'h000F, ld_cnt);
        chk("address", 16'h0A08, ld_adr);
        pop(16'h000A);
        buffer_read <= 1'b1;
        $display("test buffer done");
    endtask
    task t_abort;
        slow <= 1'b1;
        start(8'h03, 5'h06);
        wl;
        bus(1'b0, 4'h9, 8'h02);
        idle;
        pop(16'h0006);
        start(8'h01, 5'h07);
        wl;
        bus(1'b0, 4'h9, 8'h00);
        idle;
        bus(1'b1, 4'h7, 8'h00);
        chk("done pkts", 16'h0000, rv);
        bus(1'b0, 4'hA, 8'h01);
        start(8'h03, 5'h04);
        wl;
        partner_enable <= 1'b0;
        idle;
        pop(16'h0004);
        partner_enable <= 1'b1;
        slow <= 1'b0;
        $display("test abort done");
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        finish_test;
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        t_regs;
        t_buf;
        t_abort;
        finish_test;
    end
endmodule // tb_top
`default_nettype wire
